// ==== rtl/vga_plane_memory_path.v ====
// VGA planar access mapping into packed graphics memory, with its two control registers.
`include "vga_plane_memory_path_consts.vh"
`default_nettype none
module vga_plane_memory_path
(
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Register port.
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_ack,
  // VGA access request from the core.
  input  wire        vga_req,
  input  wire        vga_we,
  input  wire [15:0] vga_addr,
  input  wire [7:0]  vga_wdata,
  // Plane data returned by graphics memory for a read.
  input  wire [31:0] mem_rdata,
  // Mapped access toward graphics memory.
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [3:0]  mem_plane_en,
  // Read answer to the core.
  output reg         vga_rvalid,
  output reg  [7:0]  vga_rdata,
  // Display latch contents.
  output reg  [31:0] latch_out
);

  reg [31:0] read_ctrl_reg;
  reg [31:0] write_ctrl_reg;
  reg        rd_pend_reg;
  reg [1:0]  rd_plane_reg;
  reg [31:0] latch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Field views of the control registers.
  wire [1:0] read_plane_select      = read_ctrl_reg[`RD_PLANE_SEL_HI:`RD_PLANE_SEL_LO];
  wire       force_top_address_zero = read_ctrl_reg[`RD_FORCE15_BIT];
  wire       packed_quad_chain      = read_ctrl_reg[`RD_PACKED_BIT];
  wire       quad_chain_mode        = read_ctrl_reg[`RD_QUAD_BIT];
  wire       page_select_bit        = read_ctrl_reg[`RD_PAGE_BIT];
  wire       odd_even_chaining      = read_ctrl_reg[`RD_ODDEVEN_BIT];
  wire       write_pair_chain       = read_ctrl_reg[`RD_WPAIR_BIT];
  wire       read_pair_chain        = read_ctrl_reg[`RD_RPAIR_BIT];
  wire       read_mode_select       = read_ctrl_reg[`RD_MODE_BIT];
  wire [3:0] compare_plane_mask     = read_ctrl_reg[`RD_CMASK_HI:`RD_CMASK_LO];
  wire [3:0] compare_color_value    = read_ctrl_reg[`RD_CCOLOR_HI:`RD_CCOLOR_LO];
  wire [3:0] map_mask               = write_ctrl_reg[`WR_MAPMASK_HI:`WR_MAPMASK_LO];
  wire       set_reset_write_mode   = write_ctrl_reg[`WR_MODE2_BIT];
  wire       masked_rotate_write_mode = write_ctrl_reg[`WR_MODE3_BIT];
  wire [2:0] rotate_amount          = write_ctrl_reg[`WR_ROT_HI:`WR_ROT_LO];
  wire [3:0] plane_override_enable  = write_ctrl_reg[`WR_OVEN_HI:`WR_OVEN_LO];
  wire [3:0] plane_override_value   = write_ctrl_reg[`WR_OVVAL_HI:`WR_OVVAL_LO];
  wire [7:0] bit_mask               = write_ctrl_reg[`WR_BITMASK_HI:`WR_BITMASK_LO];

  // Planes selected by the low address bits under chaining, used for reads and writes.
  function [3:0] chain_planes;
    input       quad;
    input       pair;
    input [1:0] low;
    begin
      if (quad)
        chain_planes = 4'h1 << low;
      else if (pair)
        chain_planes = low[0] ? 4'ha : 4'h5;
      else
        chain_planes = 4'hf;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register decode, shared by the write and read halves of the register port.
  // Only the two control words are mapped; every other offset falls through.
  function hits_offset;
    input [15:0] addr;
    input [15:0] offset;
    begin
      hits_offset = (addr == offset);
    end
  endfunction

  wire sel_read_ctrl  = hits_offset(reg_addr, `READ_CTRL_OFFSET);
  wire sel_write_ctrl = hits_offset(reg_addr, `WRITE_CTRL_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Address mapping shared by both directions.
  reg [15:0] addr_map;
  always @*
  begin
    addr_map = vga_addr;
    if (quad_chain_mode && packed_quad_chain)
      addr_map = {2'b00, vga_addr[15:2]};
    if (odd_even_chaining)
      addr_map[0] = page_select_bit;
    if (force_top_address_zero)
      addr_map[15] = 1'b0;
  end

  // Chained plane sets; pair chaining is chosen per direction.
  wire [3:0] wr_chain = chain_planes(quad_chain_mode, write_pair_chain, vga_addr[1:0]);
  wire [3:0] rd_chain = chain_planes(quad_chain_mode, read_pair_chain, vga_addr[1:0]);
  wire       rd_chained = quad_chain_mode || read_pair_chain;

  // Rotated write byte.
  // Shifting a doubled byte gives the rotation without a separate mux per bit.
  wire [15:0] rot_dbl   = {vga_wdata, vga_wdata} >> rotate_amount;
  wire [7:0]  rot_data  = rot_dbl[7:0];
  wire [7:0]  mode3_msk = bit_mask & rot_data;

  ////////////////////////////////////////////////////////////////////////////
  // Per-plane write data: source choice, then bit mask merge with the latch.
  reg [31:0] wr_planes;
  integer p;
  always @*
  begin
    wr_planes = 32'h0000_0000;
    for (p = 0; p < 4; p = p + 1)
    begin
      if (set_reset_write_mode || masked_rotate_write_mode)
        wr_planes[p*8 +: 8] = {8{plane_override_value[p]}};
      else if (plane_override_enable[p])
        wr_planes[p*8 +: 8] = {8{plane_override_value[p]}};
      else
        wr_planes[p*8 +: 8] = rot_data;
      if (masked_rotate_write_mode)
        wr_planes[p*8 +: 8] = (wr_planes[p*8 +: 8] & mode3_msk) | (latch_reg[p*8 +: 8] & ~mode3_msk);
      else
        wr_planes[p*8 +: 8] = (wr_planes[p*8 +: 8] & bit_mask) | (latch_reg[p*8 +: 8] & ~bit_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read return: one plane or color compare across included planes.
  reg [7:0] rd_byte;
  reg [7:0] match;
  integer q;
  always @*
  begin
    match = 8'hff;
    for (q = 0; q < 4; q = q + 1)
      if (compare_plane_mask[q])
        match = match & ~(mem_rdata[q*8 +: 8] ^ {8{compare_color_value[q]}});
    if (read_mode_select)
      rd_byte = match;
    else
      rd_byte = mem_rdata[rd_plane_reg*8 +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle acknowledge, reserved bits read zero.
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      read_ctrl_reg  <= `READ_CTRL_RESET;
      write_ctrl_reg <= `WRITE_CTRL_RESET;
      reg_rdata      <= 32'h0000_0000;
      reg_ack        <= 1'b0;
    end
    else
    begin
      reg_ack   <= reg_wr | reg_rd;
      reg_rdata <= 32'h0000_0000;
      if (reg_wr && sel_read_ctrl)
        read_ctrl_reg <= reg_wdata & `RD_CTRL_USED_MASK;
      if (reg_wr && sel_write_ctrl)
        write_ctrl_reg <= reg_wdata & `WR_CTRL_USED_MASK;
      if (reg_rd && sel_read_ctrl)
        reg_rdata <= read_ctrl_reg;
      if (reg_rd && sel_write_ctrl)
        reg_rdata <= write_ctrl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access pipeline: issue mapped access, catch read data one cycle later into the latch.
  // The latch is loaded on every read so later mask-merged writes see the last read.
  // Limitation: a write issued in the cycle right after a read merges with the older
  // latch, since that read's data only lands one cycle later; leave a gap between them.
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mem_req      <= 1'b0;
      mem_we       <= 1'b0;
      mem_addr     <= 16'h0000;
      mem_wdata    <= 32'h0000_0000;
      mem_plane_en <= 4'h0;
      rd_pend_reg  <= 1'b0;
      rd_plane_reg <= 2'b00;
      latch_reg    <= 32'h0000_0000;
      latch_out    <= 32'h0000_0000;
      vga_rvalid   <= 1'b0;
      vga_rdata    <= 8'h00;
    end
    else
    begin
      mem_req      <= vga_req;
      mem_we       <= vga_req & vga_we;
      rd_pend_reg  <= vga_req & ~vga_we;
      vga_rvalid   <= rd_pend_reg;
      if (vga_req)
      begin
        mem_addr     <= addr_map;
        mem_wdata    <= wr_planes;
        mem_plane_en <= vga_we ? (map_mask & wr_chain) : rd_chain;
        rd_plane_reg <= rd_chained ? vga_addr[1:0] : read_plane_select;
      end
      if (rd_pend_reg)
      begin
        vga_rdata <= rd_byte;
        latch_reg <= mem_rdata;
        latch_out <= mem_rdata;
      end
    end
  end

endmodule // vga_plane_memory_path
`default_nettype wire

// ==== rtl/vga_plane_memory_path_consts.vh ====
// Constants for the VGA plane memory path.
`ifndef VGA_PLANE_MEMORY_PATH_CONSTS_VH
`define VGA_PLANE_MEMORY_PATH_CONSTS_VH
`define READ_CTRL_OFFSET   16'h8144
`define WRITE_CTRL_OFFSET  16'h8140
`define READ_CTRL_RESET    32'h0000_0000
`define WRITE_CTRL_RESET   32'h0000_0000
`define RD_PLANE_SEL_HI    17
`define RD_PLANE_SEL_LO    16
`define RD_FORCE15_BIT     15
`define RD_PACKED_BIT      14
`define RD_QUAD_BIT        13
`define RD_PAGE_BIT        12
`define RD_ODDEVEN_BIT     11
`define RD_WPAIR_BIT       10
`define RD_RPAIR_BIT       9
`define RD_MODE_BIT        8
`define RD_CMASK_HI        7
`define RD_CMASK_LO        4
`define RD_CCOLOR_HI       3
`define RD_CCOLOR_LO       0
`define WR_MAPMASK_HI      27
`define WR_MAPMASK_LO      24
`define WR_MODE3_BIT       20
`define WR_MODE2_BIT       19
`define WR_ROT_HI          18
`define WR_ROT_LO          16
`define WR_OVEN_HI         15
`define WR_OVEN_LO         12
`define WR_OVVAL_HI        11
`define WR_OVVAL_LO        8
`define WR_BITMASK_HI      7
`define WR_BITMASK_LO      0
`define WR_CTRL_USED_MASK  32'h0f1f_ffff
`define RD_CTRL_USED_MASK  32'h0003_ffff
`endif

// ==== tb/path_chk_properties.sv ====
// Port checker for the VGA plane memory path.
`default_nettype none
module path_chk (
  input wire logic        clk_sys, sys_rst, reg_wr, reg_rd, reg_ack,
  input wire logic        vga_req, vga_we, mem_req, mem_we, vga_rvalid,
  input wire logic [31:0] reg_rdata, mem_rdata, latch_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Timing ties between requests and answers.
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack late");
  a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
  a_req_follows: assert property (vga_req |=> mem_req && mem_we == $past(vga_we)) else $error("req lost");
  a_req_cause: assert property (mem_req |-> $past(vga_req)) else $error("stray req");
  a_read_answer: assert property (vga_req && !vga_we |=> ##1 vga_rvalid) else $error("no answer");
  a_rvalid_cause: assert property (vga_rvalid |-> $past(vga_req && !vga_we, 2)) else $error("stray answer");
  // The latch only moves on a read answer, and then takes the plane data.
  a_latch_load: assert property (vga_rvalid |-> latch_out == $past(mem_rdata)) else $error("latch bad");
  a_latch_hold: assert property (!vga_rvalid && !$past(sys_rst) |-> $stable(latch_out)) else $error("latch moved");
  c_read: cover property (vga_rvalid);
  c_write: cover property (mem_req && mem_we);
  c_reg: cover property (reg_ack && reg_rdata != 32'h0);
endmodule // path_chk
bind vga_plane_memory_path path_chk path_chk_i (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_ack, .vga_req,
  .vga_we, .mem_req, .mem_we, .vga_rvalid, .reg_rdata, .mem_rdata, .latch_out);
`default_nettype wire

// ==== tb/plane_mem_model.sv ====
// Behavioural graphics memory on the far side of the path.
`default_nettype none
module plane_mem_model (
  input wire logic        clk_sys, mem_req, mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0]  mem_plane_en,
  output logic     [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] m [0:255];
  logic [31:0] hold_reg = 32'h0;
  // Outside a read the bus toggles, so stale data never passes for an answer.
  assign mem_rdata = (mem_req && !mem_we) ? m[mem_addr[7:0]] : ~hold_reg;
  initial
  begin
    for (int i = 0; i < 256; i++)
      m[i] = 32'(i) * 32'h9e37_79b1;
  end
  // Only enabled planes take the write.
  always @(posedge clk_sys)
  begin
    hold_reg <= mem_rdata;
    for (int p = 0; p < 4; p++)
      if (mem_req && mem_we && mem_plane_en[p])
        m[mem_addr[7:0]][p*8+:8] <= mem_wdata[p*8+:8];
  end
endmodule // plane_mem_model
`default_nettype wire

// ==== tb/vga_plane_memory_path_tb.sv ====
// Self-checking bench for the VGA plane memory path.
`default_nettype none
module vga_plane_memory_path_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, vga_req = 0, vga_we = 0;
  logic reg_ack, mem_req, mem_we, vga_rvalid;
  logic [15:0] reg_addr = 0, vga_addr = 0, mem_addr;
  logic [7:0] vga_wdata = 0, vga_rdata;
  logic [3:0] mem_plane_en;
  logic [31:0] reg_wdata = 0, mem_rdata, reg_rdata, mem_wdata, latch_out, rdc = 0, wc = 0, lat = 0;
  logic [31:0] lf = 32'h0000_847f;
  int err_total = 0, check_count = 0;
  vga_plane_memory_path vga_plane_memory_path_i (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .vga_req, .vga_we, .vga_addr, .vga_wdata, .mem_rdata, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_plane_en, .vga_rvalid, .vga_rdata, .latch_out);
  plane_mem_model plane_mem_model_i (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_plane_en, .mem_rdata);
  initial forever #2 clk_sys = ~clk_sys;
  // Several shifts per draw, since neighbouring states share most bits.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    for (int i = 0; i < 9; i++)
      s = {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One register access; the answer stands one cycle after the strobe is driven.
  task automatic rg(input logic wr, input logic [15:0] a, input logic [31:0] d, exp);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    #1 chk({31'h0, reg_ack}, 32'h1);
    chk(reg_rdata, wr ? 32'h0 : exp);
  endtask
  // One plane access, with the expected mapping worked out alongside.
  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d);
    logic [15:0] ea;
    logic [7:0] rot, m, src, rd;
    logic [3:0] cs;
    logic [31:0] wd, md;
    ea = (rdc[14] && rdc[13]) ? a >> 2 : a;
    if (rdc[11]) ea[0] = rdc[12];
    if (rdc[15]) ea[15] = 1'b0;
    cs = rdc[13] ? 4'h1 << a[1:0] : (we ? rdc[10] : rdc[9]) ? (a[0] ? 4'ha : 4'h5) : 4'hf;
    rot = 8'({d, d} >> wc[18:16]);
    m = wc[20] ? wc[7:0] & rot : wc[7:0];
    for (int p = 0; p < 4; p++)
    begin
      src = (wc[20] || wc[19] || wc[12+p]) ? {8{wc[8+p]}} : rot;
      wd[p*8+:8] = (src & m) | (lat[p*8+:8] & ~m);
    end
    @(posedge clk_sys);
    {vga_req, vga_we, vga_addr, vga_wdata} <= {1'b1, we, a, d};
    @(posedge clk_sys);
    vga_req <= 1'b0;
    #1 chk({mem_addr, 10'h0, mem_we, mem_req, mem_plane_en}, {ea, 10'h0, we, 1'b1, we ? wc[27:24] & cs : cs});
    md = mem_rdata;
    if (we) chk(mem_wdata, wd);
    rd = md[(rdc[13] || rdc[9] ? a[1:0] : rdc[17:16])*8+:8];
    if (rdc[8]) rd = 8'hff;
    for (int p = 0; p < 4; p++)
      if (rdc[8] && rdc[4+p]) rd = rd & ~(md[p*8+:8] ^ {8{rdc[p]}});
    if (we) return;
    @(posedge clk_sys);
    #1 chk({23'h0, vga_rvalid, vga_rdata}, {23'h0, 1'b1, rd});
    chk(latch_out, md);
    lat = md;
  endtask
  initial
  begin
    repeat (25000) @(posedge clk_sys);
    err_total++;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rg(0, 16'h8144, 0, 32'h0);
    rg(0, 16'h8140, 0, 32'h0);
    rg(0, 16'h8148, 0, 32'h0);
    $display("reset values done");
    repeat (300)
    begin
      lf = lfsr_next(lf);
      wc = lf & 32'h0f1f_ffff;
      rg(1, 16'h8140, lf, 0);
      rg(0, 16'h8140, 0, wc);
      lf = lfsr_next(lf);
      rdc = lf & 32'h0003_ffff;
      rg(1, 16'h8144, lf, 0);
      rg(0, 16'h8144, 0, rdc);
      lf = lfsr_next(lf);
      acc(0, lf[15:0], 8'h0);
      acc(1, lf[15:0], lf[23:16]);
      acc(0, lf[15:0], 8'h0);
    end
    $display("random traffic done");
    // A second reset in mid-run must bring both control words back to zero; the latch is only checked after the read that follows.
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc = 32'h0;
    wc = 32'h0;
    lat = 32'h0;
    rg(0, 16'h8144, 0, 32'h0);
    rg(0, 16'h8140, 0, 32'h0);
    acc(0, lf[15:0], 8'h0);
    $display("mid-run reset done");
    give_verdict;
  end
endmodule // vga_plane_memory_path_tb
`default_nettype wire
